// *** shared/csr_pkg.sv ***
// Package: offsets, field positions, reset values and carrier types of the status/reset bank
package csr_pkg;
    // Register indices on the host-side register port (eight-bit address)
    localparam logic [7:0] ADDR_STATUS   = 8'h0a;
    localparam logic [7:0] ADDR_RESET_ID = 8'h0b;

    // Field positions, first register
    localparam int BIT_ATTACHED  = 7;
    localparam int BIT_VLIM      = 6;
    localparam int BIT_ILIM      = 5;
    localparam int BIT_TOPUP     = 3;
    localparam int BIT_OVP       = 2;
    localparam int BIT_VLIM_MASK = 1;
    localparam int BIT_ILIM_MASK = 0;

    // Field positions, second register
    localparam int BIT_REG_RESET = 7;
    localparam int PART_LSB      = 3;
    localparam int REV_LSB       = 0;

    // Reset values
    localparam logic MASK_RESET = 1'b0;

    // Identity values: arbitrary, neutral
    localparam logic [3:0] PART_ID_VALUE  = 4'ha;
    localparam logic [1:0] REVISION_VALUE = 2'h2;

    // Internal conditions from the charger core
    typedef struct packed {
        logic attached;
        logic vlim;
        logic ilim;
        logic topup;
        logic ovp;
    } csr_cond_t;

    // Host register access strobe group
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csr_req_t;
endpackage : csr_pkg

// *** verification/tb_csr_status_reset.sv ***
// Self-checking bench for the status/mask and reset/identity register pair
`timescale 1ns/10ps

module tb_csr_status_reset;
    logic               mclk;
    logic               rstn;
    logic               clk_en;
    logic               vlim_event;
    logic               ilim_event;
    csr_pkg::csr_cond_t cond;
    csr_pkg::csr_req_t  req;
    logic [7:0]         rdata;
    logic               rvalid;
    logic               vlim_irq_pulse;
    logic               ilim_irq_pulse;
    logic               safety_timer_restart;
    logic               defaults_restore;
    int                 num_errors;
    int                 samples_checked;
    int                 cycles;
    logic [7:0]         id_exp;
    // Status bit for each condition bit, ovp first
    logic [7:0]         flag_pos [5] = '{8'h04, 8'h08, 8'h20, 8'h40, 8'h80};

    csr_status_reset u_csr_status_reset (
        .mclk                 (mclk),
        .rstn                 (rstn),
        .clk_en               (clk_en),
        .cond                 (cond),
        .req                  (req),
        .vlim_event           (vlim_event),
        .ilim_event           (ilim_event),
        .rdata                (rdata),
        .rvalid               (rvalid),
        .vlim_irq_pulse       (vlim_irq_pulse),
        .ilim_irq_pulse       (ilim_irq_pulse),
        .safety_timer_restart (safety_timer_restart),
        .defaults_restore     (defaults_restore)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Whole run is a few dozen cycles; a hang trips this early
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            $display("BAD %0t timeout", $time);
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task test_done();
        if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk8

    task chk1(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk1

    // Strobes rise at a falling edge, so the rising edge in between takes them
    // An idle edge follows, so back-to-back reads never re-raise the strobe at once
    task rd(input logic [7:0] a, input logic [7:0] exp);
        req.rd   = 1'b1;
        req.addr = a;
        @(negedge mclk);
        chk1(rvalid, 1'b1, "read valid");
        chk8(rdata, exp, "read data");
        req.rd = 1'b0;
        @(negedge mclk);
    endtask : rd

    task wr(input logic [7:0] a, input logic [7:0] d);
        req.wr    = 1'b1;
        req.addr  = a;
        req.wdata = d;
        @(negedge mclk);
        req.wr = 1'b0;
    endtask : wr

    task ev(input logic [1:0] exp);
        vlim_event = 1'b1;
        ilim_event = 1'b1;
        @(negedge mclk);
        vlim_event = 1'b0;
        ilim_event = 1'b0;
        chk1(vlim_irq_pulse, exp[1], "voltage limit pulse");
        chk1(ilim_irq_pulse, exp[0], "current limit pulse");
    endtask : ev

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        clk_en = 1'b1;
        vlim_event = 1'b0;
        ilim_event = 1'b0;
        cond = '0;
        req = '0;
        id_exp = {1'b0, csr_pkg::PART_ID_VALUE, 1'b0, csr_pkg::REVISION_VALUE};
        repeat (6) @(negedge mclk);
        rstn = 1'b1;
        @(negedge mclk);
        rd(csr_pkg::ADDR_STATUS, 8'h00);
        rd(csr_pkg::ADDR_RESET_ID, id_exp);
        for (int i = 0; i < 5; i++) begin
            cond = 5'(1 << i);
            rd(csr_pkg::ADDR_STATUS, flag_pos[i]);
        end
        cond = 5'h1f;
        rd(csr_pkg::ADDR_STATUS, 8'hec);
        cond = '0;
        wr(csr_pkg::ADDR_STATUS, 8'hff);
        rd(csr_pkg::ADDR_STATUS, 8'h03);
        ev(2'b00);
        wr(csr_pkg::ADDR_STATUS, 8'h01);
        ev(2'b10);
        wr(csr_pkg::ADDR_STATUS, 8'h02);
        ev(2'b01);
        // Zero in the command bit with every other bit set must change nothing
        wr(csr_pkg::ADDR_RESET_ID, 8'h7f);
        rd(csr_pkg::ADDR_RESET_ID, id_exp);
        rd(csr_pkg::ADDR_STATUS, 8'h02);
        // A mask write while the clock enable is low must not land
        clk_en = 1'b0;
        wr(csr_pkg::ADDR_STATUS, 8'h01);
        clk_en = 1'b1;
        rd(csr_pkg::ADDR_STATUS, 8'h02);
        wr(csr_pkg::ADDR_RESET_ID, 8'h80);
        chk1(defaults_restore, 1'b1, "restore strobe");
        chk1(safety_timer_restart, 1'b1, "timer restart");
        // Read in the restore cycle: the command bit still shows 1
        rd(csr_pkg::ADDR_RESET_ID, id_exp | 8'h80);
        chk1(defaults_restore, 1'b0, "restore strobe end");
        chk1(safety_timer_restart, 1'b0, "timer restart end");
        rd(csr_pkg::ADDR_STATUS, 8'h00);
        rd(csr_pkg::ADDR_RESET_ID, id_exp);
        ev(2'b11);
        // Mid-run reset with both masks set
        wr(csr_pkg::ADDR_STATUS, 8'h03);
        rstn = 1'b0;
        @(negedge mclk);
        rstn = 1'b1;
        @(negedge mclk);
        chk8(rdata, 8'h00, "read data after reset");
        chk1(rvalid, 1'b0, "read valid after reset");
        rd(csr_pkg::ADDR_STATUS, 8'h00);
        rd(csr_pkg::ADDR_RESET_ID, id_exp);
        rd(8'h0c, 8'h00);
        test_done();
    end
endmodule : tb_csr_status_reset

// *** verilog/csr_status_reset.sv ***
// Status/mask and register-reset/identity registers of the charger control bank
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module csr_status_reset (
    input  wire logic                mclk,
    input  wire logic                rstn,
    input  wire logic                clk_en,
    input  wire csr_pkg::csr_cond_t  cond,
    input  wire csr_pkg::csr_req_t   req,
    input  wire logic                vlim_event,
    input  wire logic                ilim_event,
    output logic [7:0]               rdata,
    output logic                     rvalid,
    output logic                     vlim_irq_pulse,
    output logic                     ilim_irq_pulse,
    output logic                     safety_timer_restart,
    output logic                     defaults_restore
);

    ////////////////////////////////////////////////////////////////////////////
    // Register-reset sequencer: a write of 1 arms it, the next cycle restores
    typedef enum logic [1:0] {CSR_IDLE, CSR_RESTORE} csr_rst_state_t;

    csr_rst_state_t state_r;
    logic           reg_rst_r;
    logic           voltage_limit_irq_mask_r;
    logic           current_limit_irq_mask_r;

    function automatic logic hit(input csr_pkg::csr_req_t r, input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction : hit

    // Decoded once so the sequencer, the strobes and the checks agree on one write
    logic cmd_wr;
    assign cmd_wr = hit(req, csr_pkg::ADDR_RESET_ID) && req.wdata[csr_pkg::BIT_REG_RESET];

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_r   <= CSR_IDLE;
            reg_rst_r <= 1'b0;
        end else if (clk_en) begin
            case (state_r)
                CSR_IDLE: begin
                    if (cmd_wr) begin
                        state_r   <= CSR_RESTORE;
                        reg_rst_r <= 1'b1;
                    end
                end
                CSR_RESTORE: begin
                    state_r   <= CSR_IDLE;
                    reg_rst_r <= 1'b0;
                end
                default: begin
                    state_r   <= CSR_IDLE;
                    reg_rst_r <= 1'b0;
                end
            endcase
        end
    end

    // Restore and timer-restart strobes, one cycle, registered from a command write in the idle state
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            defaults_restore     <= 1'b0;
            safety_timer_restart <= 1'b0;
        end else if (clk_en) begin
            defaults_restore     <= cmd_wr && state_r == CSR_IDLE;
            safety_timer_restart <= cmd_wr && state_r == CSR_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Masks; restore wins over a same-cycle write so defaults really stick
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            voltage_limit_irq_mask_r <= csr_pkg::MASK_RESET;
            current_limit_irq_mask_r <= csr_pkg::MASK_RESET;
        end else if (clk_en) begin
            if (state_r == CSR_RESTORE) begin
                voltage_limit_irq_mask_r <= csr_pkg::MASK_RESET;
                current_limit_irq_mask_r <= csr_pkg::MASK_RESET;
            end else if (hit(req, csr_pkg::ADDR_STATUS)) begin
                voltage_limit_irq_mask_r <= req.wdata[csr_pkg::BIT_VLIM_MASK];
                current_limit_irq_mask_r <= req.wdata[csr_pkg::BIT_ILIM_MASK];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pulses gated by the masks
    // Registered for clean outputs, at the cost of one cycle of latency
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            vlim_irq_pulse <= 1'b0;
            ilim_irq_pulse <= 1'b0;
        end else if (clk_en) begin
            vlim_irq_pulse <= vlim_event && !voltage_limit_irq_mask_r;
            ilim_irq_pulse <= ilim_event && !current_limit_irq_mask_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path: flags sampled live at the read strobe, answer next cycle
    // Flags are not held sticky, so a read shows the condition of its strobe cycle, one cycle before rdata
    logic [7:0] status_view;
    logic [7:0] ident_view;

    always_comb begin
        status_view = 8'h00;
        status_view[csr_pkg::BIT_ATTACHED]  = cond.attached;
        status_view[csr_pkg::BIT_VLIM]      = cond.vlim;
        status_view[csr_pkg::BIT_ILIM]      = cond.ilim;
        status_view[csr_pkg::BIT_TOPUP]     = cond.topup;
        status_view[csr_pkg::BIT_OVP]       = cond.ovp;
        status_view[csr_pkg::BIT_VLIM_MASK] = voltage_limit_irq_mask_r;
        status_view[csr_pkg::BIT_ILIM_MASK] = current_limit_irq_mask_r;
        ident_view = 8'h00;
        ident_view[csr_pkg::BIT_REG_RESET] = reg_rst_r;
        ident_view[csr_pkg::PART_LSB +: 4] = csr_pkg::PART_ID_VALUE;
        ident_view[csr_pkg::REV_LSB +: 2]  = csr_pkg::REVISION_VALUE;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end else if (clk_en) begin
            rvalid <= req.rd;
            if (req.rd) begin
                case (req.addr)
                    csr_pkg::ADDR_STATUS:   rdata <= status_view;
                    csr_pkg::ADDR_RESET_ID: rdata <= ident_view;
                    default:                rdata <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_vmask_blocks;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && voltage_limit_irq_mask_r) |=> !vlim_irq_pulse;
    endproperty
    a_vmask_blocks: assert property (p_vmask_blocks)
        else $error("voltage limit pulse escaped its mask");

    property p_vpulse_pass;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && vlim_event && !voltage_limit_irq_mask_r) |=> vlim_irq_pulse;
    endproperty
    a_vpulse_pass: assert property (p_vpulse_pass)
        else $error("unmasked voltage limit pulse lost");

    property p_imask_blocks;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && current_limit_irq_mask_r) |=> !ilim_irq_pulse;
    endproperty
    a_imask_blocks: assert property (p_imask_blocks)
        else $error("current limit pulse escaped its mask");

    property p_ipulse_pass;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && ilim_event && !current_limit_irq_mask_r) |=> ilim_irq_pulse;
    endproperty
    a_ipulse_pass: assert property (p_ipulse_pass)
        else $error("unmasked current limit pulse lost");

    property p_mask_write;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && state_r == CSR_IDLE && hit(req, csr_pkg::ADDR_STATUS)) |=>
            voltage_limit_irq_mask_r == $past(req.wdata[csr_pkg::BIT_VLIM_MASK])
            && current_limit_irq_mask_r == $past(req.wdata[csr_pkg::BIT_ILIM_MASK]);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write did not land");

    property p_frozen;
        @(posedge mclk) disable iff (!rstn)
        !clk_en |=> $stable(voltage_limit_irq_mask_r) && $stable(current_limit_irq_mask_r)
            && $stable(state_r) && $stable(rdata);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("state moved while clock enable low");

    ////////////////////////////////////////////////////////////////////////////
    // Register reset and power-on reset checks
    property p_cmd_restores;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && cmd_wr && state_r == CSR_IDLE) ##1 clk_en |=>
            !voltage_limit_irq_mask_r && !current_limit_irq_mask_r;
    endproperty
    a_cmd_restores: assert property (p_cmd_restores)
        else $error("masks not restored by register reset");

    property p_timer_restart;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && cmd_wr && state_r == CSR_IDLE) |=> safety_timer_restart;
    endproperty
    a_timer_restart: assert property (p_timer_restart)
        else $error("safety timer restart missing");

    property p_restore_strobe;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && cmd_wr && state_r == CSR_IDLE) |=> defaults_restore && reg_rst_r;
    endproperty
    a_restore_strobe: assert property (p_restore_strobe)
        else $error("register restore strobe missing");

    property p_strobe_single;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && defaults_restore) |=> !defaults_restore && !safety_timer_restart;
    endproperty
    a_strobe_single: assert property (p_strobe_single)
        else $error("restore strobe longer than one cycle");

    property p_restore_wins;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && state_r == CSR_RESTORE) |=> !voltage_limit_irq_mask_r
            && !current_limit_irq_mask_r && !reg_rst_r;
    endproperty
    a_restore_wins: assert property (p_restore_wins)
        else $error("restore cycle did not leave defaults");

    property p_self_clear;
        @(posedge mclk) disable iff (!rstn)
        (reg_rst_r && clk_en) |=> !reg_rst_r;
    endproperty
    a_self_clear: assert property (p_self_clear)
        else $error("reset command bit stuck");

    property p_zero_write_keeps;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && state_r == CSR_IDLE && hit(req, csr_pkg::ADDR_RESET_ID)
            && !req.wdata[csr_pkg::BIT_REG_RESET]) |=> $stable(voltage_limit_irq_mask_r)
            && !reg_rst_r;
    endproperty
    a_zero_write_keeps: assert property (p_zero_write_keeps)
        else $error("writing zero disturbed settings");

    property p_power_on;
        @(posedge mclk)
        !rstn |=> !reg_rst_r && !voltage_limit_irq_mask_r && !current_limit_irq_mask_r
            && !rvalid && rdata == 8'h00;
    endproperty
    a_power_on: assert property (p_power_on)
        else $error("reset left state behind");

    ////////////////////////////////////////////////////////////////////////////
    // Read path checks

    property p_ident_read;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && req.rd && req.addr == csr_pkg::ADDR_RESET_ID) |=>
            rdata[6:0] == {csr_pkg::PART_ID_VALUE, 1'b0, csr_pkg::REVISION_VALUE};
    endproperty
    a_ident_read: assert property (p_ident_read)
        else $error("identity fields wrong");

    property p_flags_live;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && req.rd && req.addr == csr_pkg::ADDR_STATUS) |=>
            rdata[7:2] == $past({cond.attached, cond.vlim, cond.ilim, 1'b0,
                                 cond.topup, cond.ovp});
    endproperty
    a_flags_live: assert property (p_flags_live)
        else $error("status flags not live");

    property p_unmapped_read;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && req.rd && req.addr != csr_pkg::ADDR_STATUS
            && req.addr != csr_pkg::ADDR_RESET_ID) |=> rdata == 8'h00;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read returned data");

    property p_read_valid;
        @(posedge mclk) disable iff (!rstn)
        clk_en |=> rvalid == $past(req.rd);
    endproperty
    a_read_valid: assert property (p_read_valid)
        else $error("read valid does not follow read strobe");

    c_reg_reset:  cover property (@(posedge mclk) disable iff (!rstn)
        cmd_wr ##1 reg_rst_r ##1 !reg_rst_r);
    c_vlim_irq:   cover property (@(posedge mclk) disable iff (!rstn) vlim_irq_pulse);
    c_mask_set:   cover property (@(posedge mclk) disable iff (!rstn)
        voltage_limit_irq_mask_r && current_limit_irq_mask_r);
    c_ilim_irq:   cover property (@(posedge mclk) disable iff (!rstn) ilim_irq_pulse);
    c_zero_write: cover property (@(posedge mclk) disable iff (!rstn)
        clk_en && hit(req, csr_pkg::ADDR_RESET_ID) && !cmd_wr);

endmodule : csr_status_reset
